// ---- rtl/mci_device.sv ----
// device end: serial command interpreter of the motor controller
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "mci_params.svh"
// Contract
// R1: mode switch selects simple or addressed protocol
// R2: characters are 1 start, 8 data, 1 stop
// R3: simple protocol runs at 9600 baud
// R4: addressed protocol runs at 19200 baud
// R5: host writes command then data 0x00-7F
// R6: decode writes 0x80, 0x82-0x89 to parameters
// R7: 0x8A sets direction from value 0-3
// R8: E0 autostop serial, E1 plain serial, E2 knobs
// R9: host refreshes speed within three seconds
// R10: A0/A1 write low/high save flag halves
// R11: read codes C0-CF return one byte; the code sends no answer to C1 or CB
// R12: D0-D5, DE, DF return status, config, versions
// R13: act only after own address, else standby
// R14: host write frame is five bytes
// R15: address bytes bit7 set, others clear
// R16: write check is masked sum of three
// R17: reply own address, or with 0x80 on error
// R18: host waits for reply before next write
// R19: two byte read request, three byte answer
// R20: read check is masked sum of three
// R21: write code equals read code plus 0x40
// R22: frames ordered address, command, data, check
// R23: unknown codes and broken frames change nothing
module mci_device import mci_pkg::*; #(
  parameter int         SMP_DIV  = `MCI_CLK_HZ / `MCI_BAUD_SMP,
  parameter int         ADV_DIV  = `MCI_CLK_HZ / `MCI_BAUD_ADV,
  parameter int         STOP_CYC = `MCI_STOP_S * `MCI_CLK_HZ,
  parameter logic [6:0] SW_VER   = 7'h11, // arbitrary value
  parameter logic [6:0] HW_VER   = 7'h22  // arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        rst,
  mci_if.dev               link,
  input  wire logic        mode_sw,
  input  wire logic [11:0] sns_cur,
  input  wire logic [11:0] sns_sup,
  input  wire logic [11:0] sns_sin,
  input  wire logic [11:0] sns_ht,
  input  wire logic [11:0] sns_bt,
  input  wire logic [13:0] sts_bits,
  output mci_prm_t         prm,
  output logic [1:0]       dir,
  output logic [13:0]      save_bits,
  output logic [13:0]      cfg1,
  output logic [13:0]      cfg2,
  output logic             serial_ctrl,
  output logic             autostop_en,
  output logic             adv_mode
);
  localparam mci_dev_t RST = '{st: S_IDLE, adr: `MCI_ADR_RST, default: '0};
  mci_dev_t    r;
  mci_dev_t    n;
  logic        rx_v;
  logic [7:0]  rx_b;
  logic        tx_rdy;
  logic        tx_go;
  logic [7:0]  sm;
  logic [14:0] w;
  logic        ok;

  // value of an addressed register, bit 14 marks a known code
  function automatic logic [14:0] word(input logic [5:0] a);
    word = {1'b1, 14'h0};
    case (a)
      `MCI_A_HT:  word[13:0] = {2'b0, sns_ht};
      `MCI_A_BT:  word[13:0] = {2'b0, sns_bt};
      `MCI_A_SUP: word[13:0] = {2'b0, sns_sup};
      `MCI_A_SIN: word[13:0] = {2'b0, sns_sin};
      `MCI_A_CUR: word[13:0] = {2'b0, sns_cur};
      `MCI_A_STS: word[13:0] = sts_bits;
      `MCI_A_SAV: word[13:0] = r.sav;
      `MCI_A_CF1: word[13:0] = r.cf1;
      `MCI_A_CF2: word[13:0] = r.cf2;
      `MCI_A_SWV: word[13:0] = {7'h0, SW_VER};
      `MCI_A_HWV: word[13:0] = {7'h0, HW_VER};
      default: begin
        if (a <= `MCI_A_THR && a != `MCI_A_GAP) begin
          word[13:0] = {2'b0, r.prm[a[3:0]]};
        end else begin
          word[14] = 1'b0; // [R23]
        end
      end
    endcase
  endfunction : word

  // one-byte answer of the simple protocol, bit 7 marks a known code
  function automatic logic [7:0] smp(input logic [7:0] c);
    logic [5:0]  a;
    logic        raw;
    logic        v;
    logic [14:0] x;
    a = {2'b0, c[3:0]};
    raw = 1'b0;
    v = 1'b1;
    case (c)
      `MCI_S_CUR: a = `MCI_A_CUR;
      `MCI_S_SUP: a = `MCI_A_SUP;
      `MCI_S_SIN: a = `MCI_A_SIN;
      `MCI_S_HT: begin
        a = `MCI_A_HT;
        raw = 1'b1;
      end
      `MCI_S_BT: begin
        a = `MCI_A_BT;
        raw = 1'b1;
      end
      `MCI_S_STL, `MCI_S_STH: begin
        a = `MCI_A_STS;
        raw = 1'b1;
      end
      `MCI_S_C1L, `MCI_S_C1H: begin
        a = `MCI_A_CF1;
        raw = 1'b1;
      end
      `MCI_S_C2L, `MCI_S_C2H: begin
        a = `MCI_A_CF2;
        raw = 1'b1;
      end
      `MCI_S_SWV: begin
        a = `MCI_A_SWV;
        raw = 1'b1;
      end
      `MCI_S_HWV: begin
        a = `MCI_A_HWV;
        raw = 1'b1;
      end
      default: v = (c >= `MCI_S_RD0 && c <= `MCI_S_RD9); // [R11]
    endcase
    x = word(a);
    if (raw) begin
      smp = {v & x[14], x[6:0]}; // [R12]
      if (c[0] && c >= `MCI_S_STL && c <= `MCI_S_C2H) begin
        smp[6:0] = x[13:7]; // [R12]
      end
    end else begin
      smp = {v & x[14], x[11:5]}; // [R11]
    end
  endfunction : smp

  // store a value at an addressed register, unknown codes ignored
  function automatic mci_dev_t put(input mci_dev_t s, input logic [5:0] a,
                                   input logic [13:0] v);
    put = s;
    case (a)
      `MCI_A_SAV: put.sav = v;
      `MCI_A_CF1: put.cf1 = v;
      `MCI_A_CF2: put.cf2 = v;
      `MCI_A_ADR: put.adr = v[6:0];
      default: begin
        if (a <= `MCI_A_THR && a != `MCI_A_GAP) begin
          put.prm[a[3:0]] = v[11:0]; // [R23]
        end
      end
    endcase
    if (a == `MCI_A_SPD) begin
      put.tmr = '0; // [R8]
    end
  endfunction : put

  mci_uart u_uart (
    .clk      (clk),
    .rst      (rst),
    .div      (r.adv ? 16'(ADV_DIV) : 16'(SMP_DIV)), // [R3] [R4]
    .rx       (link.h2d),
    .rx_valid (rx_v),
    .rx_data  (rx_b),
    .tx_start (tx_go),
    .tx_data  (r.q[r.qi]),
    .tx_rdy   (tx_rdy),
    .tx       (link.d2h)
  );

  assign tx_go = (r.qi != r.qn) && tx_rdy;

  always_comb begin
    n = r;
    sm = smp(rx_b);
    w = word(rx_b[5:0]);
    ok = (rx_b[6:0] == mci_csum(r.cmd[6:0], r.d1, r.d2)); // [R16]
    n.m1 = mode_sw;
    n.m2 = r.m1;
    if (tx_go) begin
      n.qi = r.qi + 2'd1;
    end
    if (r.ser && r.ast) begin
      if (r.tmr == 29'(STOP_CYC - 1)) begin
        n.dir = '0; // [R8] [R9]
      end else begin
        n.tmr = r.tmr + 29'd1;
      end
    end
    if (r.m2 != r.adv) begin
      n.adv = r.m2; // [R1]
      n.st = S_IDLE;
      n.qn = '0;
      n.qi = '0;
    end else if (rx_v && !r.adv) begin
      if (rx_b[7]) begin
        n.st = S_IDLE; // [R23]
        n.cmd = rx_b;
        if (rx_b == `MCI_S_AUTO || rx_b == `MCI_S_MAN) begin
          n.ser = 1'b1; // [R8]
          n.ast = (rx_b == `MCI_S_AUTO);
          n.tmr = '0;
        end else if (rx_b == `MCI_S_KNOB) begin
          n.ser = 1'b0; // [R8]
          n.ast = 1'b0;
        end else if ((rx_b >= `MCI_S_SPD && rx_b <= `MCI_S_DIR && rx_b[3:0] != 4'h1)
                     || rx_b == `MCI_S_SVL || rx_b == `MCI_S_SVH) begin
          n.st = S_DATA; // [R6] [R10]
        end else if (sm[7]) begin
          n.q[0] = {1'b0, sm[6:0]}; // [R11] [R12]
          n.qn = 2'd1;
          n.qi = '0;
        end
      end else if (r.st == S_DATA) begin
        n.st = S_IDLE;
        if (r.cmd == `MCI_S_DIR) begin
          if (rx_b <= `MCI_DIR_MAX) begin
            n.dir = rx_b[1:0]; // [R7]
          end
        end else if (r.cmd == `MCI_S_SVL) begin
          n = put(n, `MCI_A_SAV, {r.sav[13:7], rx_b[6:0]}); // [R10]
        end else if (r.cmd == `MCI_S_SVH) begin
          n = put(n, `MCI_A_SAV, {rx_b[6:0], r.sav[6:0]}); // [R10]
        end else begin
          n = put(n, {2'b0, r.cmd[3:0]}, {2'b0, rx_b[6:0], 5'h0}); // [R6]
        end
      end
    end else if (rx_v) begin
      if (rx_b[7]) begin
        n.st = (rx_b[6:0] == r.adr) ? A_CMD : S_IDLE; // [R13] [R15]
      end else begin
        unique case (r.st)
          S_IDLE, S_DATA: n.st = r.st; // [R13]
          A_CMD: begin
            n.cmd = rx_b; // [R22]
            if (rx_b[6]) begin
              n.st = A_D1;
            end else if (w[14]) begin
              n.q[0] = {1'b0, w[13:7]}; // [R19]
              n.q[1] = {1'b0, w[6:0]};
              n.q[2] = {1'b0, mci_csum(rx_b[6:0], w[13:7], w[6:0])}; // [R20]
              n.qn = 2'd3;
              n.qi = '0;
            end
          end
          A_D1: begin
            n.d1 = rx_b[6:0];
            n.st = A_D2;
          end
          A_D2: begin
            n.d2 = rx_b[6:0];
            n.st = A_CHK;
          end
          A_CHK: begin
            n.st = A_CMD;
            n.q[0] = {!ok, r.adr}; // [R17]
            n.qn = 2'd1;
            n.qi = '0;
            if (ok) begin
              n = put(n, r.cmd[5:0], {r.d1, r.d2}); // [R21]
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  assign prm         = r.prm;
  assign dir         = r.dir;
  assign save_bits   = r.sav;
  assign cfg1        = r.cf1;
  assign cfg2        = r.cf2;
  assign serial_ctrl = r.ser;
  assign autostop_en = r.ast;
  assign adv_mode    = r.adv;
endmodule : mci_device

// ---- rtl/mci_params.svh ----
// constants for the motor serial command interpreter
`ifndef MCI_PARAMS_SVH
`define MCI_PARAMS_SVH
`define MCI_CLK_HZ   125000000
`define MCI_BAUD_SMP 9600
`define MCI_BAUD_ADV 19200
`define MCI_STOP_S   3
`define MCI_RFS_MS   1000
`define MCI_TMO_MS   10
`define MCI_MS_PER_S 1000
`define MCI_ADR_RST  7'h00
`define MCI_MASK7    8'h7F
`define MCI_S_SPD    8'h80
`define MCI_S_THR    8'h89
`define MCI_S_DIR    8'h8A
`define MCI_S_SVL    8'hA0
`define MCI_S_SVH    8'hA1
`define MCI_S_AUTO   8'hE0
`define MCI_S_MAN    8'hE1
`define MCI_S_KNOB   8'hE2
`define MCI_S_RD0    8'hC0
`define MCI_S_RD9    8'hC9
`define MCI_S_CUR    8'hCA
`define MCI_S_SUP    8'hCC
`define MCI_S_SIN    8'hCD
`define MCI_S_HT     8'hCE
`define MCI_S_BT     8'hCF
`define MCI_S_STL    8'hD0
`define MCI_S_STH    8'hD1
`define MCI_S_C1L    8'hD2
`define MCI_S_C1H    8'hD3
`define MCI_S_C2L    8'hD4
`define MCI_S_C2H    8'hD5
`define MCI_S_SWV    8'hDE
`define MCI_S_HWV    8'hDF
`define MCI_DIR_MAX  8'h03
`define MCI_A_SPD    6'h00
`define MCI_A_GAP    6'h01
`define MCI_A_THR    6'h09
`define MCI_A_HT     6'h0A
`define MCI_A_BT     6'h0B
`define MCI_A_SUP    6'h10
`define MCI_A_SIN    6'h11
`define MCI_A_CUR    6'h12
`define MCI_A_STS    6'h30
`define MCI_A_SAV    6'h32
`define MCI_A_CF1    6'h34
`define MCI_A_CF2    6'h35
`define MCI_A_ADR    6'h3C
`define MCI_A_SWV    6'h3E
`define MCI_A_HWV    6'h3F
`define MCI_R_CFG    8'h00
`define MCI_R_DAT    8'h04
`define MCI_R_CMD    8'h08
`define MCI_R_STS    8'h0C
`define MCI_R_RDT    8'h10
`define MCI_HSIZE_W  3'h2
`endif

// ---- rtl/mci_pkg.sv ----
// types and checksum shared by both ends
`include "mci_params.svh"
package mci_pkg;
  typedef enum logic [2:0] {S_IDLE, S_DATA, A_CMD, A_D1, A_D2, A_CHK} mci_dst_t;
  typedef enum logic [1:0] {H_IDLE, H_SEND, H_WAIT} mci_hst_t;
  typedef logic [9:0][11:0] mci_prm_t;
  typedef struct packed {
    logic s1; logic s2; logic ron; logic [15:0] rcnt; logic [3:0] rbit;
    logic [7:0] rsh; logic rv; logic [7:0] rd; logic ton; logic [15:0] tcnt;
    logic [3:0] tbit; logic [9:0] tsh; logic tx;
  } mci_uart_t;
  typedef struct packed {
    logic m1; logic m2; logic adv; mci_dst_t st; logic [7:0] cmd;
    logic [6:0] d1; logic [6:0] d2; logic [6:0] adr; mci_prm_t prm;
    logic [1:0] dir; logic [13:0] sav; logic [13:0] cf1; logic [13:0] cf2;
    logic ser; logic ast; logic [28:0] tmr; logic [2:0][7:0] q;
    logic [1:0] qn; logic [1:0] qi;
  } mci_dev_t;
  typedef struct packed {
    mci_hst_t st; logic [6:0] adr; logic adv; logic rfs; logic [6:0] d1;
    logic [6:0] d2; logic [7:0] cmd; logic done; logic err; logic tmo;
    logic [6:0] rd1; logic [6:0] rd2; logic [4:0][7:0] q; logic [2:0] qn;
    logic [2:0] qi; logic [1:0] rn; logic [1:0] rc; logic [23:0] tc;
    logic [26:0] rt; logic [6:0] sd1; logic [6:0] sd2; logic svld;
    logic aw; logic [7:0] aa; logic [31:0] hrd;
  } mci_host_t;

  function automatic logic [6:0] mci_csum(input logic [6:0] c, input logic [6:0] a,
                                          input logic [6:0] b);
    logic [7:0] s;
    s = {1'b0, c} + {1'b0, a} + {1'b0, b};
    s = s & `MCI_MASK7;
    return s[6:0];
  endfunction : mci_csum
endpackage : mci_pkg

// ---- rtl/mci_if.sv ----
// serial link between host and device
`timescale 1ns/1ps
interface mci_if;
  logic h2d;
  logic d2h;
  modport dev  (input h2d, output d2h);
  modport host (output h2d, input d2h);
endinterface : mci_if

// ---- rtl/mci_uart.sv ----
// 8n1 serial receiver and transmitter with run-time bit period
`timescale 1ns/1ps
`include "mci_params.svh"
module mci_uart import mci_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] div,
  input  wire logic        rx,
  output logic             rx_valid,
  output logic [7:0]       rx_data,
  input  wire logic        tx_start,
  input  wire logic [7:0]  tx_data,
  output logic             tx_rdy,
  output logic             tx
);
  localparam mci_uart_t RST = '{s1: 1'b1, s2: 1'b1, tx: 1'b1, default: '0};
  mci_uart_t r;
  mci_uart_t n;

  always_comb begin
    n = r;
    n.s1 = rx;
    n.s2 = r.s1;
    n.rv = 1'b0;
    if (!r.ron) begin
      if (!r.s2) begin
        n.ron = 1'b1;
        n.rcnt = div >> 1;
        n.rbit = '0;
      end
    end else if (r.rcnt != '0) begin
      n.rcnt = r.rcnt - 16'd1;
    end else begin
      n.rcnt = div - 16'd1;
      n.rbit = r.rbit + 4'd1;
      if (r.rbit == 4'd0) begin
        n.ron = !r.s2;
      end else if (r.rbit == 4'd9) begin
        n.ron = 1'b0;
        n.rv = r.s2; // [R2]
        n.rd = r.rsh;
      end else begin
        n.rsh = {r.s2, r.rsh[7:1]};
      end
    end
    if (!r.ton) begin
      if (tx_start) begin
        n.ton = 1'b1;
        n.tsh = {1'b1, tx_data, 1'b0}; // [R2]
        n.tcnt = div - 16'd1;
        n.tbit = '0;
      end
    end else if (r.tcnt != '0) begin
      n.tcnt = r.tcnt - 16'd1;
    end else begin
      n.tcnt = div - 16'd1;
      n.tsh = {1'b1, r.tsh[9:1]};
      n.tbit = r.tbit + 4'd1;
      n.ton = (r.tbit != 4'd9);
    end
    n.tx = n.ton ? n.tsh[0] : 1'b1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  assign rx_valid = r.rv;
  assign rx_data  = r.rd;
  assign tx_rdy   = !r.ton;
  assign tx       = r.tx;
endmodule : mci_uart

// ---- rtl/mci_host.sv ----
// host end: ahb-lite controlled serial master for the motor controller
`timescale 1ns/1ps
`include "mci_params.svh"
module mci_host import mci_pkg::*; #(
  parameter int SMP_DIV = `MCI_CLK_HZ / `MCI_BAUD_SMP,
  parameter int ADV_DIV = `MCI_CLK_HZ / `MCI_BAUD_ADV,
  parameter int RFS_CYC = `MCI_RFS_MS * (`MCI_CLK_HZ / `MCI_MS_PER_S),
  parameter int TMO_CYC = `MCI_TMO_MS * (`MCI_CLK_HZ / `MCI_MS_PER_S)
) (
  input  wire logic        clk,
  input  wire logic        rst,
  mci_if.host              link,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp
);
  localparam mci_host_t RST = '{st: H_IDLE, adr: `MCI_ADR_RST, default: '0};
  mci_host_t  r;
  mci_host_t  n;
  logic       rx_v;
  logic [7:0] rx_b;
  logic       tx_rdy;
  logic       tx_go;
  logic [7:0] spd;

  // build the byte queue of one transaction
  function automatic mci_host_t go(input mci_host_t s, input logic [7:0] c,
                                   input logic [6:0] a, input logic [6:0] b);
    go = s;
    go.cmd = c;
    go.st = H_SEND;
    go.qi = '0;
    go.rc = '0;
    go.tc = '0;
    go.rt = '0;
    go.done = 1'b0;
    go.err = 1'b0;
    go.tmo = 1'b0;
    if (s.adv) begin
      go.q[0] = {1'b1, s.adr}; // [R15] [R22]
      go.q[1] = {1'b0, c[6:0]};
      go.q[2] = {1'b0, a};
      go.q[3] = {1'b0, b};
      go.q[4] = {1'b0, mci_csum(c[6:0], a, b)}; // [R16]
      go.qn = c[6] ? 3'd5 : 3'd2; // [R14] [R19]
      go.rn = c[6] ? 2'd1 : 2'd3;
    end else begin
      go.q[0] = c;
      go.q[1] = {1'b0, a}; // [R5]
      go.qn = (c[7:6] == 2'b10) ? 3'd2 : 3'd1;
      go.rn = (c[7:5] == 3'b110) ? 2'd1 : 2'd0;
    end
    if (c == spd) begin
      go.sd1 = a;
      go.sd2 = b;
      go.svld = 1'b1;
    end
  endfunction : go

  function automatic logic [31:0] rdreg(input logic [7:0] a);
    case (a)
      `MCI_R_CFG: rdreg = {22'h0, r.rfs, r.adv, 1'b0, r.adr};
      `MCI_R_DAT: rdreg = {17'h0, r.d2, 1'b0, r.d1};
      `MCI_R_CMD: rdreg = {24'h0, r.cmd};
      `MCI_R_STS: rdreg = {28'h0, r.tmo, r.err, r.done, r.st != H_IDLE};
      `MCI_R_RDT: rdreg = {17'h0, r.rd2, 1'b0, r.rd1};
      default:    rdreg = 32'h0;
    endcase
  endfunction : rdreg

  mci_uart u_uart (
    .clk      (clk),
    .rst      (rst),
    .div      (r.adv ? 16'(ADV_DIV) : 16'(SMP_DIV)), // [R3] [R4]
    .rx       (link.d2h),
    .rx_valid (rx_v),
    .rx_data  (rx_b),
    .tx_start (tx_go),
    .tx_data  (r.q[r.qi]),
    .tx_rdy   (tx_rdy),
    .tx       (link.h2d)
  );

  assign tx_go = (r.st == H_SEND) && tx_rdy;
  assign spd   = r.adv ? {2'b01, `MCI_A_SPD} : `MCI_S_SPD;

  always_comb begin
    n = r;
    if (hready) begin
      n.aw = hsel && htrans[1] && hwrite && hsize == `MCI_HSIZE_W;
      n.aa = haddr[7:0];
      if (hsel && htrans[1] && !hwrite) begin
        n.hrd = rdreg(haddr[7:0]);
      end
    end
    if (r.aw && r.aa == `MCI_R_CFG) begin
      n.adr = hwdata[6:0];
      n.adv = hwdata[8];
      n.rfs = hwdata[9];
    end else if (r.aw && r.aa == `MCI_R_DAT) begin
      n.d1 = hwdata[6:0];
      n.d2 = hwdata[14:8];
    end else if (r.aw && r.aa == `MCI_R_CMD && r.st == H_IDLE) begin
      n = go(n, hwdata[7:0], r.d1, r.d2); // [R18]
    end
    if (r.rfs && r.svld && n.st == H_IDLE) begin
      if (r.rt == 27'(RFS_CYC - 1)) begin
        n = go(n, spd, r.sd1, r.sd2); // [R9]
      end else begin
        n.rt = r.rt + 27'd1;
      end
    end
    if (tx_go) begin
      n.qi = r.qi + 3'd1;
      if (r.qi == r.qn - 3'd1) begin
        n.st = (r.rn == 2'd0) ? H_IDLE : H_WAIT; // [R18]
        n.done = (r.rn == 2'd0);
      end
    end
    if (r.st == H_WAIT) begin
      n.tc = r.tc + 24'd1;
      if (rx_v) begin
        n.rc = r.rc + 2'd1;
        if (r.rc == 2'd0) begin
          n.rd1 = rx_b[6:0];
          n.err = r.adv && r.rn == 2'd1 && rx_b != {1'b0, r.adr}; // [R17]
        end else if (r.rc == 2'd1) begin
          n.rd2 = rx_b[6:0];
        end else begin
          n.err = rx_b[6:0] != mci_csum(r.cmd[6:0], r.rd1, r.rd2); // [R20]
        end
        if (r.rc == r.rn - 2'd1) begin
          n.st = H_IDLE;
          n.done = 1'b1;
        end
      end else if (r.tc == 24'(TMO_CYC - 1)) begin
        n.st = H_IDLE;
        n.tmo = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  assign hrdata    = r.hrd;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
endmodule : mci_host

// ---- bench/mci_link_sva.sv ----
// checker for the two serial lines between host and device
`timescale 1ns/1ps
module mci_link_sva #(
  parameter int BIT_MIN = 8,
  parameter int LOW_MAX = 144
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic h2d,
  input wire logic d2h
);
  logic [7:0] run_h;
  logic [7:0] run_d;
  // samples spent at the present level of each line
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_h <= 8'hFF;
      run_d <= 8'hFF;
    end else begin
      run_h <= $changed(h2d) ? 8'h01 : run_h + {7'h0, run_h != 8'hFF};
      run_d <= $changed(d2h) ? 8'h01 : run_d + {7'h0, run_d != 8'hFF};
    end
  end
  h2d_bit_len_a: assert property (@(posedge clk) disable iff (rst)
    $changed(h2d) |-> run_h >= BIT_MIN) else $error("short level on host line");
  d2h_bit_len_a: assert property (@(posedge clk) disable iff (rst)
    $changed(d2h) |-> run_d >= BIT_MIN) else $error("short level on device line");
  h2d_low_len_a: assert property (@(posedge clk) disable iff (rst)
    !h2d && !$changed(h2d) |-> run_h < LOW_MAX) else $error("host line low past a character");
  d2h_low_len_a: assert property (@(posedge clk) disable iff (rst)
    !d2h && !$changed(d2h) |-> run_d < LOW_MAX) else $error("device line low past a character");
  idle_rst_a: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> (h2d && d2h) [*8]) else $error("line not idle after reset");
  reply_start_a: assert property (@(posedge clk) disable iff (rst)
    $fell(d2h) |-> h2d && run_h >= 4) else $error("reply before request ended");
  half_duplex_a: assert property (@(posedge clk) disable iff (rst)
    !d2h |-> h2d) else $error("both lines low together");
  host_start_a: assert property (@(posedge clk) disable iff (rst)
    $fell(h2d) |-> $past(d2h)) else $error("host started during a reply");
endmodule : mci_link_sva

// ---- bench/tb_top.sv ----
// bench: host and device joined over the serial link, plus a rogue link
`timescale 1ns/1ps
module tb_top import mci_pkg::*; ;
  localparam int SD = 16;
  localparam int AD = 8;
  localparam int STP = 2000;
  logic        clk, rst, hsel, hwrite, hreadyout, hresp, mode_sw;
  logic        serial_ctrl, autostop_en, adv_mode;
  logic        rd_pend = 1'b0;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, dir;
  logic [2:0]  hsize;
  logic [11:0] sns_cur, sns_sup, sns_sin, sns_ht, sns_bt;
  logic [13:0] sts_bits, save_bits, cfg1, cfg2;
  mci_prm_t    prm, prm2;
  logic [63:0] expq[$];
  int          n_errors = 0;
  int          num_checks = 0;
  mci_if link();
  mci_if link2();
  mci_host #(.SMP_DIV(SD), .ADV_DIV(AD), .RFS_CYC(1000), .TMO_CYC(400)) i_mci_host (
    .clk(clk), .rst(rst), .link(link), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  mci_device #(.SMP_DIV(SD), .ADV_DIV(AD), .STOP_CYC(STP)) i_mci_device (
    .clk(clk), .rst(rst), .link(link), .mode_sw(mode_sw), .sns_cur(sns_cur),
    .sns_sup(sns_sup), .sns_sin(sns_sin), .sns_ht(sns_ht), .sns_bt(sns_bt),
    .sts_bits(sts_bits), .prm(prm), .dir(dir), .save_bits(save_bits), .cfg1(cfg1),
    .cfg2(cfg2), .serial_ctrl(serial_ctrl), .autostop_en(autostop_en), .adv_mode(adv_mode));
  mci_device #(.SMP_DIV(SD), .ADV_DIV(AD), .STOP_CYC(STP)) i_mci_device_2 (
    .clk(clk), .rst(rst), .link(link2), .mode_sw(1'b1), .sns_cur(sns_cur),
    .sns_sup(sns_sup), .sns_sin(sns_sin), .sns_ht(sns_ht), .sns_bt(sns_bt),
    .sts_bits(sts_bits), .prm(prm2), .dir(), .save_bits(), .cfg1(), .cfg2(),
    .serial_ctrl(), .autostop_en(), .adv_mode());
  mci_link_sva #(.BIT_MIN(AD), .LOW_MAX(9 * SD)) i_mci_link_sva (
    .clk(clk), .rst(rst), .h2d(link.h2d), .d2h(link.d2h));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic test_done();
    if (n_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m);
    if (!w)
      expq.push_back({e, m});
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1)
      @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1)
      @(posedge clk);
  endtask : ahb

  // start one transaction, wait until idle, then note the expected status
  task automatic txn(input logic [7:0] c, input logic [6:0] a, input logic [6:0] b,
                     input logic [31:0] e, input logic [31:0] m);
    logic [31:0] s;
    ahb(8'h04, 1'b1, {17'h0, b, 1'b0, a}, 32'h0, 32'h0);
    ahb(8'h08, 1'b1, {24'h0, c}, 32'h0, 32'h0);
    s = 32'h1;
    while (s[0] !== 1'b0) begin
      ahb(8'h0C, 1'b0, 32'h0, 32'h0, 32'h0);
      s = hrdata;
    end
    // on simple-protocol writes busy drops as the last byte starts, let that byte land first
    repeat (11 * SD) @(posedge clk);
    ahb(8'h0C, 1'b0, 32'h0, e, m);
  endtask : txn

  task automatic ser_tx(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      link2.h2d <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
      repeat (AD) @(posedge clk);
    end
  endtask : ser_tx

  task automatic ser_rx(output logic [7:0] b);
    int n;
    n = 0;
    while (link2.d2h !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    repeat (AD / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (AD) @(posedge clk);
      b[i] = link2.d2h;
    end
  endtask : ser_rx

  // read results: oldest note against the data phase
  always @(posedge clk) begin
    logic [63:0] ev;
    if (rd_pend && hreadyout === 1'b1 && expq.size() > 0) begin
      ev = expq.pop_front();
      check(hrdata & ev[31:0], ev[63:32] & ev[31:0]);
    end
    if (hreadyout === 1'b1)
      rd_pend <= hsel && htrans[1] && !hwrite;
  end

  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    test_done();
  end

  initial begin
    logic [31:0] s;
    logic [6:0]  v, w, a, b;
    logic [6:0]  pv [10];
    logic [7:0]  rc [12];
    logic [6:0]  rx [12];
    logic [7:0]  fr [5];
    logic [7:0]  r;
    rst = 1'b1;
    {hsel, hwrite, mode_sw} = 3'h0;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    {sns_cur, sns_sup, sns_sin, sns_ht, sns_bt, sts_bits} = 74'h0;
    link2.h2d = 1'b1;
    s = $urandom(32'hD774CC29);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    {sns_cur, sns_sup, sns_sin, sns_ht, sns_bt} <= 60'({$urandom, $urandom});
    sts_bits <= 14'($urandom);
    // lines stay idle for the post-reset window
    repeat (8) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      pv[i] = 7'($urandom);
      txn(8'h80 + 8'(i), pv[i], 7'h0, 32'h2, 32'hF);
      check(32'(prm[i]), (i == 1) ? 32'h0 : {20'h0, pv[i], 5'h0});
    end
    for (int i = 0; i < 5; i++) begin
      txn(8'h8A, 7'(i), 7'h0, 32'h2, 32'hF);
      check(32'(dir), (i < 4) ? 32'(i) : 32'h3);
    end
    txn(8'hE1, 7'h0, 7'h0, 32'h2, 32'hF);
    check(32'({serial_ctrl, autostop_en}), 32'h2);
    v = 7'($urandom);
    w = 7'($urandom);
    txn(8'hA0, v, 7'h0, 32'h2, 32'hF);
    txn(8'hA1, w, 7'h0, 32'h2, 32'hF);
    check(32'(save_bits), 32'({w, v}));
    txn(8'hE0, 7'h0, 7'h0, 32'h2, 32'hF);
    txn(8'h8A, 7'h1, 7'h0, 32'h2, 32'hF);
    txn(8'h80, v, 7'h0, 32'h2, 32'hF);
    check(32'({serial_ctrl, autostop_en, dir}), 32'hD);
    ahb(8'h00, 1'b1, 32'h200, 32'h0, 32'h0);
    repeat (STP + 200) @(posedge clk);
    check(32'(dir), 32'h1);
    ahb(8'h00, 1'b1, 32'h0, 32'h0, 32'h0);
    repeat (STP + 600) @(posedge clk);
    check(32'(dir), 32'h0);
    txn(8'hE2, 7'h0, 7'h0, 32'h2, 32'hF);
    check(32'(serial_ctrl), 32'h0);
    rc = '{8'hC0, 8'hCA, 8'hCC, 8'hCD, 8'hCE, 8'hCF, 8'hD0, 8'hD1, 8'hD2, 8'hD5, 8'hDE, 8'hDF};
    rx = '{v, sns_cur[11:5], sns_sup[11:5], sns_sin[11:5], sns_ht[6:0], sns_bt[6:0],
           sts_bits[6:0], sts_bits[13:7], 7'h0, 7'h0, 7'h11, 7'h22};
    for (int i = 0; i < 12; i++) begin
      txn(rc[i], 7'h0, 7'h0, 32'h2, 32'hF);
      ahb(8'h10, 1'b0, 32'h0, {25'h0, rx[i]}, 32'h7F);
    end
    mode_sw <= 1'b1;
    ahb(8'h00, 1'b1, 32'h100, 32'h0, 32'h0);
    a = 7'($urandom);
    b = 7'($urandom);
    txn(8'h40, a, b, 32'h2, 32'hF);
    check(32'({adv_mode, prm[0]}), {19'h0, 1'b1, a[4:0], b});
    txn(8'h00, 7'h0, 7'h0, 32'h2, 32'hF);
    ahb(8'h10, 1'b0, 32'h0, {17'h0, b, 3'h0, a[4:0]}, 32'h7F7F);
    txn(8'h7C, 7'h0, 7'h05, 32'h2, 32'hF);
    txn(8'h42, 7'h01, 7'h02, 32'h8, 32'h8);
    check(32'(prm[2]), {20'h0, pv[2], 5'h0});
    ahb(8'h00, 1'b1, 32'h105, 32'h0, 32'h0);
    txn(8'h42, 7'h01, 7'h02, 32'h2, 32'hF);
    check(32'(prm[2]), 32'h82);
    fr = '{8'h80, 8'h40, 8'h01, 8'h02, 8'h00};
    for (int j = 0; j < 2; j++) begin
      fr[4] = j ? 8'h43 : 8'h00;
      foreach (fr[i])
        ser_tx(fr[i]);
      ser_rx(r);
      check(32'(r), j ? 32'h0 : 32'h80);
      check(32'(prm2[0]), j ? 32'h82 : 32'h0);
    end
    test_done();
  end
endmodule : tb_top
